// ---- ctec_top.sv ----
// Purpose: control and status of a charge-time edge measurement unit
// Assumes: software on a plain strobe port, sources from on-chip peers
// Notes: analog current source is outside; this block drives its controls
//
// Contract
// - control bit 9 grounds current source output
// - trigger output only while bit 8 set
// - two-bit edge source selectors, four sources
// - bit 1 flags detected second edge
// - bit 0 flags detected first edge
// - bit 7 picks second edge polarity
// - current register bits 9-8 select range
// - current register bits 7-0 read zero
// - edge pass enable blocks or passes edges
// - order enforce: second edge needs first
//
// Local design decisions: strobed register access and the address map.
module ctec_top import ctec_pkg::*; (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // register port
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // edge sources
    input wire logic TIMER_ONE,
    input wire logic OUTPUT_COMPARE_ONE,
    input wire logic FIRST_EDGE_PIN,
    input wire logic SECOND_EDGE_PIN,
    // analog controls
    output logic MODULE_ON,
    output logic CURRENT_SOURCE_ON,
    output logic CURRENT_SOURCE_GROUND,
    output logic TRIGGER_OUT,
    output logic DELAY_GENERATION_ENABLE,
    output logic [1:0] CURRENT_RANGE_SELECT,
    output logic [5:0] CURRENT_TRIM_FIELD,
    // interrupt
    output logic IRQ
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [15:0] ctrl_r;
    logic [15:0] cur_r;
    logic first_seen_r, second_seen_r;
    logic [1:0] irq_stat_r, irq_mask_r;
    logic pin1_s, pin2_s;
    logic hit1, hit2;
    logic pass1, pass2;
    logic wr_ctrl, wr_cur, wr_mask, rd_stat;

    assign wr_ctrl = WR && (ADDR == CTEC_OFS_CONTROL);
    assign wr_cur = WR && (ADDR == CTEC_OFS_CURRENT);
    assign wr_mask = WR && (ADDR == CTEC_OFS_IRQ_MASK);
    assign rd_stat = RD && (ADDR == CTEC_OFS_IRQ_STAT);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // index 0 is the first edge pin, index 1 the second
    logic [1:0] pin_raw;
    logic [1:0] pin_sync;

    assign pin_raw = {SECOND_EDGE_PIN, FIRST_EDGE_PIN};
    assign pin1_s = pin_sync[0];
    assign pin2_s = pin_sync[1];

    for (genvar p = 0; p < 2; p++) begin : g_sync
        ctec_sync u_ctec_sync (
            .clk(MCLK),
            .rst_n(RST_N),
            .d(pin_raw[p]),
            .q(pin_sync[p])
        );
    end

    // ----------------------------------------
    // edge channels
    // ----------------------------------------
    // index 0 is the first edge channel, index 1 the second
    logic [1:0] edge_sel [2];
    logic [1:0] edge_pol;
    logic [1:0] hit_v;

    assign edge_sel[0] = ctrl_r[CTEC_BIT_E1_SEL_HI:CTEC_BIT_E1_SEL_LO];
    assign edge_sel[1] = ctrl_r[CTEC_BIT_E2_SEL_HI:CTEC_BIT_E2_SEL_LO];
    assign edge_pol = {ctrl_r[CTEC_BIT_E2_POL], ctrl_r[CTEC_BIT_E1_POL]};
    assign hit1 = hit_v[0];
    assign hit2 = hit_v[1];

    for (genvar ch = 0; ch < 2; ch++) begin : g_edge
        ctec_edge u_ctec_edge (
            .clk(MCLK),
            .rst_n(RST_N),
            .sel(edge_sel[ch]),
            .pol(edge_pol[ch]),
            .src_timer(TIMER_ONE),
            .src_compare(OUTPUT_COMPARE_ONE),
            .src_pin1(pin1_s),
            .src_pin2(pin2_s),
            .hit(hit_v[ch])
        );
    end

    // blocked edges are lost, not queued
    assign pass1 = hit1 && ctrl_r[CTEC_BIT_MODULE_ON] && ctrl_r[CTEC_BIT_EDGE_PASS];
    assign pass2 = hit2 && ctrl_r[CTEC_BIT_MODULE_ON] && ctrl_r[CTEC_BIT_EDGE_PASS]
        && (!ctrl_r[CTEC_BIT_EDGE_ORDER] || first_seen_r);

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_r <= CTEC_CONTROL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= WDATA & CTEC_CONTROL_WMASK;
        end
    end

    // ----------------------------------------
    // edge status flags; an edge beats a software clear
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            first_seen_r <= 1'b0;
        end else if (pass1) begin
            first_seen_r <= 1'b1;
        end else if (wr_ctrl) begin
            first_seen_r <= WDATA[CTEC_BIT_E1_SEEN];
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            second_seen_r <= 1'b0;
        end else if (pass2) begin
            second_seen_r <= 1'b1;
        end else if (wr_ctrl) begin
            second_seen_r <= WDATA[CTEC_BIT_E2_SEEN];
        end
    end

    // ----------------------------------------
    // current control register
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cur_r <= CTEC_CURRENT_RST;
        end else if (wr_cur) begin
            cur_r <= WDATA & CTEC_CURRENT_WMASK;
        end
    end

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_stat_r <= CTEC_IRQ_RST;
        end else begin
            irq_stat_r <= (rd_stat ? 2'h0 : irq_stat_r) | {pass2, pass1};
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_mask_r <= CTEC_IRQ_RST;
        end else if (wr_mask) begin
            irq_mask_r <= WDATA[1:0];
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(((rd_stat ? 2'h0 : irq_stat_r) | {pass2, pass1}) & irq_mask_r);
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            if (ADDR == CTEC_OFS_CONTROL) begin
                RDATA <= {ctrl_r[15:2], second_seen_r, first_seen_r};
            end else if (ADDR == CTEC_OFS_CURRENT) begin
                RDATA <= cur_r;
            end else if (ADDR == CTEC_OFS_IRQ_STAT) begin
                RDATA <= {14'h0000, irq_stat_r};
            end else if (ADDR == CTEC_OFS_IRQ_MASK) begin
                RDATA <= {14'h0000, irq_mask_r};
            end else begin
                RDATA <= 16'h0000;
            end
        end else begin
            RDATA <= 16'h0000;
        end
    end

    // ----------------------------------------
    // analog control outputs
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            MODULE_ON <= 1'b0;
            CURRENT_SOURCE_ON <= 1'b0;
            CURRENT_SOURCE_GROUND <= 1'b0;
            TRIGGER_OUT <= 1'b0;
            DELAY_GENERATION_ENABLE <= 1'b0;
            CURRENT_RANGE_SELECT <= 2'h0;
            CURRENT_TRIM_FIELD <= 6'h00;
        end else begin
            MODULE_ON <= ctrl_r[CTEC_BIT_MODULE_ON];
            // source charges between first and second edge
            CURRENT_SOURCE_ON <= ctrl_r[CTEC_BIT_MODULE_ON] && (first_seen_r ^ second_seen_r);
            CURRENT_SOURCE_GROUND <= ctrl_r[CTEC_BIT_GROUND];
            TRIGGER_OUT <= ctrl_r[CTEC_BIT_TRIG] && ctrl_r[CTEC_BIT_MODULE_ON]
                && (first_seen_r ^ second_seen_r);
            // pins for delay mode are mapped by software beforehand
            DELAY_GENERATION_ENABLE <= ctrl_r[CTEC_BIT_DELAY_GEN];
            CURRENT_RANGE_SELECT <= cur_r[CTEC_BIT_RANGE_HI:CTEC_BIT_RANGE_LO];
            CURRENT_TRIM_FIELD <= cur_r[CTEC_BIT_TRIM_HI:CTEC_BIT_TRIM_LO];
        end
    end
endmodule // ctec_top

// ---- ctec_pkg.sv ----
// Purpose: shared constants for the charge-time edge control block
// Assumes: 16-bit registers on a plain strobe port
// Notes: offsets are register indexes on the plain port
package ctec_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [3:0] CTEC_OFS_CONTROL = 4'h0;
    localparam logic [3:0] CTEC_OFS_CURRENT = 4'h1;
    localparam logic [3:0] CTEC_OFS_IRQ_STAT = 4'h2;
    localparam logic [3:0] CTEC_OFS_IRQ_MASK = 4'h3;
    // ----------------------------------------
    // control field positions
    // ----------------------------------------
    localparam int CTEC_BIT_MODULE_ON = 15;
    localparam int CTEC_BIT_DELAY_GEN = 12;
    localparam int CTEC_BIT_EDGE_PASS = 11;
    localparam int CTEC_BIT_EDGE_ORDER = 10;
    localparam int CTEC_BIT_GROUND = 9;
    localparam int CTEC_BIT_TRIG = 8;
    localparam int CTEC_BIT_E2_POL = 7;
    localparam int CTEC_BIT_E2_SEL_HI = 6;
    localparam int CTEC_BIT_E2_SEL_LO = 5;
    localparam int CTEC_BIT_E1_POL = 4;
    localparam int CTEC_BIT_E1_SEL_HI = 3;
    localparam int CTEC_BIT_E1_SEL_LO = 2;
    localparam int CTEC_BIT_E2_SEEN = 1;
    localparam int CTEC_BIT_E1_SEEN = 0;
    // writable bits of the control word (bit 14 unimplemented)
    localparam logic [15:0] CTEC_CONTROL_WMASK = 16'hBFFC;
    // ----------------------------------------
    // current control fields
    // ----------------------------------------
    localparam int CTEC_BIT_TRIM_HI = 15;
    localparam int CTEC_BIT_TRIM_LO = 10;
    localparam int CTEC_BIT_RANGE_HI = 9;
    localparam int CTEC_BIT_RANGE_LO = 8;
    localparam logic [15:0] CTEC_CURRENT_WMASK = 16'hFF00;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [15:0] CTEC_CONTROL_RST = 16'h0000;
    localparam logic [15:0] CTEC_CURRENT_RST = 16'h0000;
    localparam logic [1:0] CTEC_IRQ_RST = 2'h0;
    // ----------------------------------------
    // edge source codes
    // ----------------------------------------
    localparam logic [1:0] CTEC_SRC_TIMER = 2'h0;
    localparam logic [1:0] CTEC_SRC_COMPARE = 2'h1;
    localparam logic [1:0] CTEC_SRC_PIN2 = 2'h2;
    localparam logic [1:0] CTEC_SRC_PIN1 = 2'h3;
endpackage

// ---- ctec_sync.sv ----
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: asynchronous input
// Notes: output changes once stages two and three agree
module ctec_sync import ctec_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic s1_r, s2_r, s3_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= 1'b0;
        end else if (s2_r == s3_r) begin
            q <= s3_r;
        end
    end
endmodule // ctec_sync

// ---- ctec_edge.sv ----
// Purpose: source select and polarity edge detector for one edge channel
// Assumes: all sources already in the clock domain
// Notes: one-cycle pulse on the chosen transition
module ctec_edge import ctec_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] sel,
    input wire logic pol,
    input wire logic src_timer,
    input wire logic src_compare,
    input wire logic src_pin1,
    input wire logic src_pin2,
    output logic hit
);
    logic level;
    logic prev_r;

    always_comb begin
        case (sel)
            CTEC_SRC_PIN1: level = src_pin1;
            CTEC_SRC_PIN2: level = src_pin2;
            CTEC_SRC_COMPARE: level = src_compare;
            default: level = src_timer;
        endcase
    end

    // previous level is not reloaded on a select change: switching onto a
    // source at another level looks like an edge, so change selects while idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= level;
        end
    end

    // pol high: rising transition counts; low: falling
    assign hit = pol ? (level & ~prev_r) : (~level & prev_r);
endmodule // ctec_edge

// ---- ctec_chk.sv ----
// Purpose: port-level checks for the charge-time edge control block
// Assumes: one clock, async active-low reset
// Notes: outputs lag their register source by one cycle
module ctec_chk import ctec_pkg::*; (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // register port
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    // analog controls
    input wire logic MODULE_ON,
    input wire logic CURRENT_SOURCE_ON,
    input wire logic CURRENT_SOURCE_GROUND,
    input wire logic TRIGGER_OUT,
    input wire logic [1:0] CURRENT_RANGE_SELECT,
    input wire logic [5:0] CURRENT_TRIM_FIELD
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    a_ground_copy: assert property (
        WR && ADDR == 4'h0 |-> ##2 CURRENT_SOURCE_GROUND == $past(WDATA[9], 2))
        else $error("ground output wrong");
    a_trig_off: assert property (
        WR && ADDR == 4'h0 && !WDATA[8] |-> ##2 !TRIGGER_OUT) else $error("trigger not off");
    a_trig_gate: assert property (
        TRIGGER_OUT |-> MODULE_ON && CURRENT_SOURCE_ON) else $error("trigger outside window");
    a_ctl_read: assert property (
        (WR && ADDR == 4'h0) ##2 (RD && ADDR == 4'h0)
        |=> (RDATA & 16'hBFFC) == ($past(WDATA, 3) & 16'hBFFC)) else $error("control readback");
    a_range_copy: assert property (
        WR && ADDR == 4'h1 |-> ##2 CURRENT_RANGE_SELECT == $past(WDATA[9:8], 2))
        else $error("range output wrong");
    a_trim_copy: assert property (
        WR && ADDR == 4'h1 |-> ##2 CURRENT_TRIM_FIELD == $past(WDATA[15:10], 2))
        else $error("trim output wrong");
    a_low_zero: assert property (
        RD && ADDR == 4'h1 |=> RDATA[7:0] == 8'h00) else $error("low byte not zero");
    a_rdata_idle: assert property (
        !RD |=> RDATA == 16'h0000) else $error("read data without read");
endmodule // ctec_chk

bind ctec_top ctec_chk u_ctec_chk (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .MODULE_ON(MODULE_ON),
    .CURRENT_SOURCE_ON(CURRENT_SOURCE_ON), .CURRENT_SOURCE_GROUND(CURRENT_SOURCE_GROUND),
    .TRIGGER_OUT(TRIGGER_OUT), .CURRENT_RANGE_SELECT(CURRENT_RANGE_SELECT),
    .CURRENT_TRIM_FIELD(CURRENT_TRIM_FIELD));

// ---- ctec_peer.sv ----
// Purpose: edge sources seen by the block: timer, compare, two pins
// Assumes: pins already routed before delay generation is used
// Notes: one pulse of 8 cycles on the chosen source, others stay low
module ctec_peer (
    // control
    input wire logic clk,
    input wire logic [1:0] sel,
    input wire logic fire,
    // sources
    output logic tmr,
    output logic cmp,
    output logic pin1,
    output logic pin2
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r = 4'h0;
    always_ff @(posedge clk) begin
        if (fire) cnt_r <= 4'h8;
        else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    end
    // long enough for the pin synchroniser to agree
    assign tmr = cnt_r != 4'h0 && sel == 2'h0;
    assign cmp = cnt_r != 4'h0 && sel == 2'h1;
    assign pin2 = cnt_r != 4'h0 && sel == 2'h2;
    assign pin1 = cnt_r != 4'h0 && sel == 2'h3;
endmodule // ctec_peer

// ---- test_charge_time_edge_control.sv ----
// Purpose: self-checking bench for the charge-time edge control block
// Assumes: plain strobe register port, 200 MHz clock
// Notes: edges come from the peer model
module test_charge_time_edge_control import ctec_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_n, wr, rd, fire, tmr, cmp, p1, p2, mod_on, cs_on, gnd, trig, dge, irq;
    logic [3:0] addr;
    logic [15:0] wdata, rdata;
    logic [1:0] psel, rng;
    logic [5:0] trim;
    int mismatches, num_checks;
    ctec_top u_ctec_top (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .TIMER_ONE(tmr), .OUTPUT_COMPARE_ONE(cmp),
        .FIRST_EDGE_PIN(p1), .SECOND_EDGE_PIN(p2), .MODULE_ON(mod_on),
        .CURRENT_SOURCE_ON(cs_on), .CURRENT_SOURCE_GROUND(gnd), .TRIGGER_OUT(trig),
        .DELAY_GENERATION_ENABLE(dge), .CURRENT_RANGE_SELECT(rng),
        .CURRENT_TRIM_FIELD(trim), .IRQ(irq));
    ctec_peer u_ctec_peer (.clk(mclk), .sel(psel), .fire(fire), .tmr(tmr), .cmp(cmp),
        .pin1(p1), .pin2(p2));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        rd <= 1'b1; addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic pulse(input logic [1:0] s);
        @(posedge mclk);
        psel <= s; fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        repeat (16) @(posedge mclk);
    endtask
    task automatic t_regs();
        for (int a = 0; a < 4; a++) rd_chk(4'(a), 16'h0000);
        wr_reg(4'h1, 16'hFFFF);
        rd_chk(4'h1, 16'hFF00);
        wr_reg(4'h0, 16'hBFFC);
        rd_chk(4'h0, 16'hBFFC);
        chk({5'h00, mod_on, dge, gnd, rng, trim}, 16'h07FF);
        wr_reg(4'h0, 16'h0000);
        wr_reg(4'h9, 16'hFFFF);
        rd_chk(4'h9, 16'h0000);
        chk({13'h0000, mod_on, dge, gnd}, 16'h0000);
    endtask
    task automatic t_edges();
        logic [15:0] ctl;
        wr_reg(4'h3, 16'h0003);
        for (int e = 0; e < 2; e++) begin
            for (int s = 0; s < 4; s++) begin
                // other channel watches a source that stays idle
                ctl = 16'h8800 | (16'(s) << (2 + 3 * e)) | (16'(s % 2) << (4 + 3 * e))
                    | (16'((s + 1) % 4) << (5 - 3 * e));
                wr_reg(4'h0, ctl);
                pulse(2'(s));
                chk({15'h0000, irq}, 16'h0001);
                rd_chk(4'h0, ctl | (16'h0001 << e));
                rd_chk(4'h2, 16'h0001 << e);
                chk({15'h0000, irq}, 16'h0000);
                wr_reg(4'h0, 16'h0000);
            end
        end
    endtask
    task automatic t_order();
        wr_reg(4'h3, 16'h0000);
        wr_reg(4'h0, 16'h8010);
        pulse(2'h0);
        rd_chk(4'h0, 16'h8010);
        wr_reg(4'h0, 16'h8D90);
        pulse(2'h0);
        rd_chk(4'h0, 16'h8D91);
        chk({13'h0000, cs_on, trig, irq}, 16'h0006);
        rd_chk(4'h2, 16'h0001);
        pulse(2'h0);
        rd_chk(4'h0, 16'h8D93);
        chk({14'h0000, cs_on, trig}, 16'h0000);
        wr_reg(4'h0, 16'h0000);
    endtask
    task automatic final_report();
        if (mismatches == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        rst_n = 1'b0; wr = 1'b0; rd = 1'b0; fire = 1'b0;
        addr = 4'h0; wdata = 16'h0000; psel = 2'h0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_edges();
        t_order();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        final_report();
    end
endmodule // test_charge_time_edge_control
